//--- hdl/lpc_ctrl.sv
// Function
// - Sleep stops only the processor clock
// - Any peripheral interrupt or event ends sleep
// - Stop gates core clocks and all oscillators but RC during a grant
// - Regulator mode in stop set by configuration
// - Any external event line ends stop
// - Regulator back to normal before granting clock
// - Standby turns off regulator and all oscillators
// - Reset, watchdog, wakeup edge, RTC exit standby
// - RTC and watchdog clocks keep running always
// - Internal RC oscillator selected after reset
// - External clock monitored while it is selected
// - Clock failure falls back to internal RC
// - Clock failure interrupt only when enabled
// - Interrupt on PLL input clock loss
// - Prescalers derive bus clocks, software limits rate
`timescale 1ns/1ps
`default_nettype none

module lpc_ctrl
  import lpc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // Wake sources, asynchronous
  input  wire logic [15:0]       external_event_lines_i,
  input  wire logic              supply_monitor_output_i,
  input  wire logic              rtc_event_i,
  input  wire logic              first_two_wire_port_wake_i,
  input  wire logic              first_serial_port_wake_i,
  input  wire logic [1:0]        comparator_outputs_i,
  input  wire logic              cec_wake_i,
  input  wire logic              wakeup_pin_i,
  input  wire logic              independent_watchdog_rst_i,
  input  wire logic              external_reset_pin_n_i,
  // RC clock requests: cec, serial, two-wire; asynchronous
  input  wire logic [2:0]        rc_clk_req_i,
  // External oscillator divided by eight, asynchronous
  input  wire logic              ext_osc_div8_i,
  // Same-domain sources
  input  wire logic              periph_irq_i,
  input  wire logic              pll_src_lost_i,
  // Clock and power controls
  output logic                   cpu_clk_en_o,
  output logic                   core_clk_en_o,
  output logic                   internal_rc_oscillator_en_o,
  output logic                   external_crystal_oscillator_en_o,
  output logic                   pll_en_o,
  output logic                   regulator_on_o,
  output logic                   regulator_lp_o,
  output logic                   rtc_domain_clk_en_o,
  output logic [2:0]             rc_clk_grant_o,
  output logic [1:0]             sys_clk_sel_o,
  output logic                   bus_clk_en_o,
  output logic                   periph_clk_en_o,
  output logic                   chip_reset_o,
  output logic                   irq_o
);

  localparam int unsigned SYNC_W = 30;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(REG_SETTLE_CYC - 1);
  localparam logic [CNT_W-1:0] CSS_LAST = CNT_W'(CSS_TIMEOUT_CYC - 1);
  localparam logic [CNT_W-1:0] STBY_LAST = CNT_W'(STBY_RST_CYC - 1);

  lpc_state_t           state_r;
  logic [SYNC_W-1:0]    sync1_r, sync2_r;
  logic [CNT_W-1:0]     cnt_r, css_cnt_r;
  logic [1:0]           mode_r, clk_sel_r;
  logic [DIV_W-1:0]     hdiv_r, pdiv_r, hcnt_r, pcnt_r;
  logic [IRQ_W-1:0]     irq_stat_r, irq_mask_r, irq_set;
  logic [DATA_W-1:0]    rdata_r;
  logic [2:0]           rc_req;
  logic                 wakeup_pin_d_r, osc_d_r, pll_lost_d_r, ext_ok_r;
  logic                 reg_lp_r, ext_en_r, pll_en_r;
  logic                 evt_any, stby_wake, enter_req, soft_clr;
  logic                 css_fail, core_run;

  // Register write decode
  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    return wr_i && (addr_i == off);
  endfunction

  // Two-stage synchronisers for every pin-side input, then edge history
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r      <= '0;
      sync2_r      <= '0;
      wakeup_pin_d_r     <= 1'b0;
      osc_d_r      <= 1'b0;
      pll_lost_d_r <= 1'b0;
    end else begin
      sync1_r <= {external_event_lines_i, supply_monitor_output_i,
                  rtc_event_i, first_two_wire_port_wake_i,
                  first_serial_port_wake_i, comparator_outputs_i,
                  cec_wake_i, wakeup_pin_i, independent_watchdog_rst_i,
                  ~external_reset_pin_n_i, rc_clk_req_i, ext_osc_div8_i};
      sync2_r      <= sync1_r;
      wakeup_pin_d_r     <= sync2_r[6]; // Second stage only, never the first
      osc_d_r      <= sync2_r[0];
      pll_lost_d_r <= pll_src_lost_i;
    end
  end

  // Decoded wake conditions
  assign rc_req    = sync2_r[3:1];
  assign evt_any   = |sync2_r[29:7];
  assign stby_wake = (sync2_r[6] & ~wakeup_pin_d_r) | sync2_r[5] | sync2_r[4]
                   | sync2_r[12];
  assign enter_req = wr_hit(REG_CTRL) && wdata_i[CTRL_ENTER_BIT]
                   && (wdata_i[CTRL_MODE_LSB +: 2] != 2'h0);
  assign soft_clr  = (state_r == ST_STBY_EXIT);

  // Power state machine
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_RUN;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        ST_RUN: begin
          cnt_r <= '0;
          if (enter_req) begin
            case (wdata_i[CTRL_MODE_LSB +: 2])
              MODE_SLEEP: state_r <= ST_SLEEP;
              MODE_STOP:  state_r <= ST_STOP;
              default:    state_r <= ST_STANDBY;
            endcase
          end
        end
        ST_SLEEP: begin
          if (periph_irq_i || evt_any) state_r <= ST_RUN;
        end
        ST_STOP: begin
          cnt_r <= '0;
          if (evt_any) begin
            state_r <= ST_RUN;
          end else if (|rc_req) begin
            // Low-power regulator cannot carry the RC load yet
            state_r <= reg_lp_r ? ST_STOP_REG : ST_STOP_GRANT;
          end
        end
        ST_STOP_REG: begin
          cnt_r <= cnt_r + 1'b1;
          if (evt_any) begin
            state_r <= ST_RUN;
          end else if (!(|rc_req)) begin
            state_r <= ST_STOP;
          end else if (cnt_r == SETTLE_LAST) begin
            state_r <= ST_STOP_GRANT;
          end
        end
        ST_STOP_GRANT: begin
          if (evt_any) begin
            state_r <= ST_RUN;
          end else if (!(|rc_req)) begin
            state_r <= ST_STOP;
          end
        end
        ST_STANDBY: begin
          cnt_r <= '0;
          if (stby_wake) begin
            state_r <= ST_STBY_EXIT;
          end
        end
        ST_STBY_EXIT: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == STBY_LAST) begin
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
          cnt_r   <= '0;
        end
      endcase
    end
  end

  // Control register; lost across standby like all core state except the ext_ok_r flag
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {reg_lp_r, mode_r} <= 3'(CTRL_RST);
    end else if (soft_clr) begin
      {reg_lp_r, mode_r} <= 3'(CTRL_RST);
    end else if (wr_hit(REG_CTRL)) begin
      mode_r   <= wdata_i[CTRL_MODE_LSB +: 2];
      reg_lp_r <= wdata_i[CTRL_REG_LP_BIT];
    end
  end

  // Clock configuration; failure override wins over software
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {pdiv_r, hdiv_r, pll_en_r, ext_en_r, clk_sel_r} <= CLKCFG_RST;
    end else if (soft_clr) begin
      {pdiv_r, hdiv_r, pll_en_r, ext_en_r, clk_sel_r} <= CLKCFG_RST;
    end else if (css_fail) begin
      clk_sel_r <= SEL_RC;
    end else if (wr_hit(REG_CLKCFG)) begin
      clk_sel_r <= wdata_i[CLK_SEL_LSB +: 2];
      ext_en_r  <= wdata_i[CLK_EXT_EN_BIT];
      pll_en_r  <= wdata_i[CLK_PLL_EN_BIT];
      hdiv_r    <= wdata_i[CLK_HDIV_LSB +: DIV_W];
      pdiv_r    <= wdata_i[CLK_PDIV_LSB +: DIV_W];
    end
  end

  // External clock monitor: missing edges for the timeout means failure
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      css_cnt_r <= '0;
      ext_ok_r  <= 1'b0;
    end else if (clk_sel_r != SEL_EXT || !core_run) begin
      css_cnt_r <= '0;
    end else if (sync2_r[0] != osc_d_r) begin
      css_cnt_r <= '0;
      ext_ok_r  <= 1'b1;
    end else if (css_fail) begin
      css_cnt_r <= '0;
      ext_ok_r  <= 1'b0;
    end else begin
      css_cnt_r <= css_cnt_r + 1'b1;
    end
  end

  assign css_fail = (clk_sel_r == SEL_EXT) && core_run
                 && (sync2_r[0] == osc_d_r) && (css_cnt_r == CSS_LAST);

  // Event sources for the sticky status bits
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_CLK_FAIL]  = css_fail;
    irq_set[IRQ_PLL_LOST]  = pll_en_r && pll_src_lost_i
                          && !pll_lost_d_r;
    irq_set[IRQ_STOP_WAKE] = (state_r == ST_STOP) && evt_any;
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat_r <= IRQ_RST;
    end else if (soft_clr) begin
      irq_stat_r <= IRQ_RST;
    end else if (wr_hit(REG_IRQ_STAT)) begin
      irq_stat_r <= (irq_stat_r & ~wdata_i[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_mask_r <= IRQ_RST;
    end else if (soft_clr) begin
      irq_mask_r <= IRQ_RST;
    end else if (wr_hit(REG_IRQ_MASK)) begin
      irq_mask_r <= wdata_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_stat_r & irq_mask_r);

  // Bus and peripheral clock prescalers, divide by field plus one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hcnt_r <= '0;
      pcnt_r <= '0;
    end else if (!core_run) begin
      hcnt_r <= '0;
      pcnt_r <= '0;
    end else if (hcnt_r >= hdiv_r) begin
      hcnt_r <= '0;
      pcnt_r <= (pcnt_r >= pdiv_r) ? '0 : pcnt_r + 1'b1;
    end else begin
      hcnt_r <= hcnt_r + 1'b1;
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= '0;
    end else if (!rd_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= '0;
      case (addr_i)
        REG_CTRL: begin
          rdata_r[CTRL_MODE_LSB +: 2]  <= mode_r;
          rdata_r[CTRL_REG_LP_BIT]     <= reg_lp_r;
        end
        REG_CLKCFG: begin
          rdata_r[CLK_SEL_LSB +: 2]     <= clk_sel_r;
          rdata_r[CLK_EXT_EN_BIT]       <= ext_en_r;
          rdata_r[CLK_PLL_EN_BIT]       <= pll_en_r;
          rdata_r[CLK_HDIV_LSB +: DIV_W] <= hdiv_r;
          rdata_r[CLK_PDIV_LSB +: DIV_W] <= pdiv_r;
        end
        REG_STATUS: begin
          rdata_r[STAT_STATE_LSB +: 3] <= state_r;
          rdata_r[STAT_SEL_LSB +: 2]   <= clk_sel_r;
          rdata_r[STAT_EXT_OK]         <= ext_ok_r;
        end
        REG_IRQ_STAT: rdata_r[IRQ_W-1:0] <= irq_stat_r;
        REG_IRQ_MASK: rdata_r[IRQ_W-1:0] <= irq_mask_r;
        default:      rdata_r <= '0;
      endcase
    end
  end

  assign rdata_o = rdata_r;

  // Clock and power gating from the state
  assign core_run      = (state_r == ST_RUN) || (state_r == ST_SLEEP);
  assign cpu_clk_en_o  = (state_r == ST_RUN);
  assign core_clk_en_o = core_run;
  assign internal_rc_oscillator_en_o =
    core_run || (state_r == ST_STOP_GRANT);
  assign external_crystal_oscillator_en_o = core_run && ext_en_r;
  assign pll_en_o       = core_run && pll_en_r;
  assign regulator_on_o = (state_r != ST_STANDBY);
  assign regulator_lp_o = (state_r == ST_STOP) && reg_lp_r;
  assign rc_clk_grant_o =
    (state_r == ST_STOP_GRANT) ? rc_req : 3'h0;
  // Always-on domain is never gated by this block
  assign rtc_domain_clk_en_o = 1'b1;
  assign sys_clk_sel_o   = clk_sel_r;
  assign bus_clk_en_o    = core_run && (hcnt_r >= hdiv_r);
  assign periph_clk_en_o = bus_clk_en_o && (pcnt_r >= pdiv_r);
  assign chip_reset_o    = (state_r == ST_STBY_EXIT);

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_sleep_cpu_only: assert property (
    state_r == ST_SLEEP |-> !cpu_clk_en_o && core_clk_en_o)
    else $error("sleep gates more than the cpu clock");
  a_sleep_irq_wake: assert property (
    state_r == ST_SLEEP && periph_irq_i |=> cpu_clk_en_o)
    else $error("sleep not ended by interrupt");
  a_stop_clocks_off: assert property (
    state_r == ST_STOP |-> !core_clk_en_o && !pll_en_o
      && !internal_rc_oscillator_en_o && !external_crystal_oscillator_en_o)
    else $error("clock running in stop");
  a_stop_reg_mode: assert property (
    state_r == ST_STOP |-> regulator_lp_o == reg_lp_r)
    else $error("stop regulator mode wrong");
  a_stop_evt_wake: assert property (
    state_r == ST_STOP && evt_any |=> state_r == ST_RUN ##1 cpu_clk_en_o)
    else $error("stop not ended by event line");
  a_grant_reg_first: assert property (
    $rose(|rc_clk_grant_o) && reg_lp_r
      |-> !$past(regulator_lp_o, 2) && internal_rc_oscillator_en_o)
    else $error("rc clock granted before regulator normal");
  a_stby_all_off: assert property (
    state_r == ST_STANDBY |-> !regulator_on_o && !pll_en_o
      && !internal_rc_oscillator_en_o && !external_crystal_oscillator_en_o)
    else $error("supply or oscillator on in standby");
  a_stby_exit_rst: assert property (
    state_r == ST_STANDBY && stby_wake |=> chip_reset_o [*8])
    else $error("standby exit reset too short");
  a_rtc_runs: assert property (
    !core_run |-> rtc_domain_clk_en_o)
    else $error("rtc domain clock gated");
  a_exit_rc_sel: assert property (
    chip_reset_o && !$past(chip_reset_o) |=> sys_clk_sel_o == SEL_RC)
    else $error("rc not selected after restart");
  a_fail_fallback: assert property (
    css_fail |=> sys_clk_sel_o == SEL_RC && irq_stat_r[IRQ_CLK_FAIL])
    else $error("no fallback on clock failure");
  a_fail_irq_gate: assert property (
    irq_stat_r[IRQ_CLK_FAIL] && !irq_mask_r[IRQ_CLK_FAIL]
      && irq_stat_r[IRQ_W-1:1] == '0 |-> !irq_o)
    else $error("clock failure interrupt not gated");

  c_sleep_wake:  cover property (state_r == ST_SLEEP ##1 state_r == ST_RUN);
  c_stop_grant:  cover property (state_r == ST_STOP_REG
                                 ##1 state_r == ST_STOP_GRANT);
  c_stby_exit:   cover property (state_r == ST_STBY_EXIT
                                 ##1 state_r == ST_RUN);
  c_clk_failure: cover property (css_fail);

endmodule

`default_nettype wire

//--- pkg/lpc_pkg.sv
package lpc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_CLKCFG   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_ENTER_BIT  = 2;
  localparam int unsigned CTRL_REG_LP_BIT = 3;

  // Low-power mode codes
  localparam logic [1:0] MODE_SLEEP   = 2'h1;
  localparam logic [1:0] MODE_STOP    = 2'h2;
  localparam logic [1:0] MODE_STANDBY = 2'h3;

  // Clock configuration fields
  localparam int unsigned CLK_SEL_LSB    = 0;
  localparam int unsigned CLK_EXT_EN_BIT = 2;
  localparam int unsigned CLK_PLL_EN_BIT = 3;
  localparam int unsigned CLK_HDIV_LSB   = 4;
  localparam int unsigned CLK_PDIV_LSB   = 8;
  localparam int unsigned DIV_W          = 4;

  // System clock source codes
  localparam logic [1:0] SEL_RC  = 2'h0;
  localparam logic [1:0] SEL_EXT = 2'h1;
  localparam logic [1:0] SEL_PLL = 2'h2;

  // Status register fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_SEL_LSB   = 4;
  localparam int unsigned STAT_EXT_OK    = 6;

  // Interrupt status / mask bits
  localparam int unsigned IRQ_CLK_FAIL  = 0;
  localparam int unsigned IRQ_PLL_LOST  = 1;
  localparam int unsigned IRQ_STOP_WAKE = 2;
  localparam int unsigned IRQ_W         = 3;

  // Reset values
  localparam logic [3:0]       CTRL_RST   = 4'h0;
  localparam logic [11:0]      CLKCFG_RST = 12'h000;
  localparam logic [IRQ_W-1:0] IRQ_RST    = 3'h0;

  // Timing, clock is 40 MHz
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  localparam int unsigned REG_SETTLE_NS   = 1000;
  localparam int unsigned CSS_TIMEOUT_NS  = 2000;
  localparam int unsigned STBY_RST_NS     = 500;
  localparam int unsigned REG_SETTLE_CYC  =
    (REG_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CSS_TIMEOUT_CYC =
    (CSS_TIMEOUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STBY_RST_CYC    =
    (STBY_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W           = 8;

  // Power state machine
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STOP_REG,
    ST_STOP_GRANT,
    ST_STANDBY,
    ST_STBY_EXIT
  } lpc_state_t;

endpackage

//--- verification/lpc_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module lpc_far_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Crystal enable from design, failure command from bench
  input  wire logic osc_en_i,
  input  wire logic osc_dead_i,
  // Crystal divided by eight
  output logic      ext_osc_div8_o
);
  logic [4:0] cnt_r;

  // Toggles every 20 cycles; disabled or dead, it stands still
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r          <= 5'h00;
      ext_osc_div8_o <= 1'b0;
    end else if (osc_en_i && !osc_dead_i) begin
      cnt_r <= (cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
      if (cnt_r == 5'h13) begin
        ext_osc_div8_o <= ~ext_osc_div8_o;
      end
    end
  end
endmodule

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import lpc_pkg::*;
  logic              clk_i, rst_n_i, wr_i, rd_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, d;
  logic [22:0]       wake_v;
  logic              wk_pin, wdog, ext_rst_n, osc_dead, ext_osc, irq_in;
  logic              pll_lost, cpu_en, core_en, rc_en, xo_en, pll_en;
  logic              reg_on, reg_lp, rtc_en, bus_en, per_en, chip_rst, irq;
  logic [2:0]        rc_req, grant;
  logic [1:0]        sel;
  int                n_errors, samples_checked, k, j, nb, np;

  lpc_ctrl u_lpc_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .external_event_lines_i(wake_v[15:0]),
    .supply_monitor_output_i(wake_v[16]), .rtc_event_i(wake_v[17]),
    .first_two_wire_port_wake_i(wake_v[18]),
    .first_serial_port_wake_i(wake_v[19]),
    .comparator_outputs_i(wake_v[21:20]), .cec_wake_i(wake_v[22]),
    .wakeup_pin_i(wk_pin), .independent_watchdog_rst_i(wdog),
    .external_reset_pin_n_i(ext_rst_n), .rc_clk_req_i(rc_req),
    .ext_osc_div8_i(ext_osc), .periph_irq_i(irq_in),
    .pll_src_lost_i(pll_lost), .cpu_clk_en_o(cpu_en),
    .core_clk_en_o(core_en), .internal_rc_oscillator_en_o(rc_en),
    .external_crystal_oscillator_en_o(xo_en), .pll_en_o(pll_en),
    .regulator_on_o(reg_on), .regulator_lp_o(reg_lp),
    .rtc_domain_clk_en_o(rtc_en), .rc_clk_grant_o(grant),
    .sys_clk_sel_o(sel), .bus_clk_en_o(bus_en), .periph_clk_en_o(per_en),
    .chip_reset_o(chip_rst), .irq_o(irq));

  lpc_far_model u_lpc_far_model (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .osc_en_i(xo_en),
    .osc_dead_i(osc_dead), .ext_osc_div8_o(ext_osc));

  // Free-running 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // A bounded wait that ran out ends the run
  task automatic hang();
    n_errors++;
    finish_test();
  endtask

  // Sample just after the edge so its updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic wait_cpu(input int n);
    for (k = 0; k < n && cpu_en !== 1'b1; k++) tick(1);
    if (cpu_en !== 1'b1) hang();
  endtask

  task automatic t_reset();
    logic [7:0] regs [5];
    regs = '{REG_CTRL, REG_CLKCFG, REG_IRQ_STAT, REG_IRQ_MASK, 8'h14};
    chk(32'(sel), 32'(SEL_RC));
    chk(32'({cpu_en, rtc_en}), 32'h3);
    for (j = 0; j < 5; j++) begin
      rd(regs[j]);
      chk(d, 32'h0);
    end
  endtask

  task automatic t_sleep();
    wr(REG_CTRL, 32'h5);
    tick(2);
    chk(32'({cpu_en, core_en, rc_en}), 32'h3);
    nb = 0;
    repeat (8) begin
      tick(1);
      nb += int'(bus_en);
    end
    chk(32'(nb), 32'h8);
    @(posedge clk_i);
    irq_in <= 1'b1;
    tick(1);
    chk(32'(cpu_en), 32'h1);
    @(posedge clk_i);
    irq_in <= 1'b0;
  endtask

  // Low-power regulator must return to normal before the RC grant
  task automatic t_stop_lp();
    wr(REG_CTRL, 32'he);
    tick(2);
    chk(32'({cpu_en, core_en, rc_en, pll_en, xo_en}), 32'h0);
    chk(32'({reg_lp, reg_on, rtc_en}), 32'h7);
    @(posedge clk_i);
    rc_req <= 3'h2;
    for (k = 0; k < 100 && grant === 3'h0; k++) tick(1);
    if (grant === 3'h0) hang();
    chk(32'(grant), 32'h2);
    chk(32'({reg_lp, rc_en}), 32'h1);
    chk(32'(k >= int'(REG_SETTLE_CYC)), 32'h1);
    @(posedge clk_i);
    rc_req <= 3'h0;
    tick(3);
    chk(32'(grant), 32'h0);
  endtask

  // Every wake source ends stop; the first pass ends the stop above
  task automatic t_stop_wake();
    for (j = 0; j < 23; j++) begin
      wr(REG_CTRL, 32'h6);
      tick(1);
      chk(32'({core_en, reg_lp}), 32'h0);
      @(posedge clk_i);
      wake_v <= 23'h1 << j;
      wait_cpu(8);
      @(posedge clk_i);
      wake_v <= 23'h0;
      tick(3);
    end
    rd(REG_IRQ_STAT);
    chk(d & 32'h4, 32'h4);
    wr(REG_IRQ_STAT, 32'h7);
  endtask

  task automatic t_standby();
    for (j = 0; j < 4; j++) begin
      wr(REG_CLKCFG, 32'hc);
      wr(REG_CTRL, 32'h7);
      tick(2);
      chk(32'({reg_on, rc_en, xo_en, pll_en, rtc_en}), 32'h1);
      if (j == 0) begin
        @(posedge clk_i);
        wake_v <= 23'h1;
        tick(6);
        chk(32'(reg_on), 32'h0);
      end
      @(posedge clk_i);
      wake_v    <= (j == 3) ? 23'h20000 : 23'h0;
      wk_pin    <= (j == 0);
      wdog      <= (j == 1);
      ext_rst_n <= (j != 2);
      for (k = 0; k < 10 && chip_rst !== 1'b1; k++) tick(1);
      if (chip_rst !== 1'b1) hang();
      chk(32'(chip_rst), 32'h1);
      @(posedge clk_i);
      wake_v    <= 23'h0;
      wk_pin    <= 1'b0;
      wdog      <= 1'b0;
      ext_rst_n <= 1'b1;
      wait_cpu(40);
      rd(REG_CLKCFG);
      chk(d, 32'h0);
    end
  endtask

  task automatic t_css();
    wr(REG_CLKCFG, 32'h5);
    tick(200);
    chk(32'(sel), 32'(SEL_EXT));
    rd(REG_STATUS);
    chk(d, 32'h50);
    @(posedge clk_i);
    osc_dead <= 1'b1;
    for (k = 0; k < 200 && sel !== SEL_RC; k++) tick(1);
    if (sel !== SEL_RC) hang();
    chk(32'(sel), 32'(SEL_RC));
    chk(32'(k >= int'(CSS_TIMEOUT_CYC) - 21), 32'h1);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h1);
    tick(1);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_STAT, 32'h1);
    tick(1);
    chk(32'(irq), 32'h0);
    @(posedge clk_i);
    osc_dead <= 1'b0;
  endtask

  task automatic t_pll_div();
    wr(REG_IRQ_MASK, 32'h2);
    wr(REG_CLKCFG, 32'h138);
    @(posedge clk_i);
    pll_lost <= 1'b1;
    tick(3);
    chk(32'(irq), 32'h1);
    chk(32'({pll_en, xo_en}), 32'h2);
    @(posedge clk_i);
    pll_lost <= 1'b0;
    wr(REG_IRQ_STAT, 32'h2);
    tick(1);
    chk(32'(irq), 32'h0);
    nb = 0;
    np = 0;
    repeat (40) begin
      tick(1);
      nb += int'(bus_en);
      np += int'(per_en);
    end
    chk(32'(nb), 32'ha);
    chk(32'(np), 32'h5);
  endtask

  // Reset held for 8 cycles, then each scenario in turn
  initial begin
    {rst_n_i, wr_i, rd_i, wk_pin, wdog, osc_dead, irq_in, pll_lost} = '0;
    {addr_i, wdata_i, wake_v, rc_req} = '0;
    ext_rst_n = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(1);
    t_reset();
    t_sleep();
    t_stop_lp();
    t_stop_wake();
    t_standby();
    t_css();
    t_pll_div();
    finish_test();
  end
endmodule

`default_nettype wire
